// File: flash_pin_pkg.sv
package flash_pin_pkg;

  // Serial framing
  localparam int OPC_BITS     = 8;
  localparam int ADDR_BITS    = 24;
  localparam int BYTE_W       = 8;
  localparam int BITC_W       = 5;
  localparam logic [4:0] OPC_LAST  = 5'h07;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] BYTE_LAST = 5'h07;

  // Array organisation
  localparam int PAGES        = 4096;
  localparam int PAGE_BITS    = 12;
  localparam int CNT_W        = 10;
  localparam logic [9:0] PAGE_LONG  = 10'h210;
  localparam logic [9:0] PAGE_SHORT = 10'h200;
  localparam int PAGE_LSB_LONG  = 10;
  localparam int PAGE_LSB_SHORT = 9;
  localparam int BUFFERS      = 2;
  localparam int OTP_BYTES    = 128;
  localparam int OTP_FACTORY  = 64;

  // Sector protection map: 16 sectors of 256 pages
  localparam int SECTORS      = 16;
  localparam int SEC_BITS     = 4;
  localparam int SEC_LSB      = 8;

  // Data path buffering
  localparam int FIFO_DEPTH   = 4;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_OPC    = 6'h02,
    ST_ADDR   = 6'h04,
    ST_DECIDE = 6'h08,
    ST_DATA   = 6'h10,
    ST_READ   = 6'h20
  } state_t;

  localparam state_t ST_IGNORE_ALIAS = ST_IDLE;

endpackage : flash_pin_pkg

// File: pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// File: byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } fifo_t;

  fifo_t            q;
  fifo_t            d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = mem[q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = bump(q.wr);
    end
    if (pop) begin
      d.rd = bump(q.rd);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[q.wr] <= in_data;
    end
  end

endmodule : byte_fifo

`default_nettype wire

// File: serial_flash_pin_interface.sv
`timescale 1ns/100ps
`default_nettype none

module serial_flash_pin_interface
  import flash_pin_pkg::*;
#(
  parameter int FIFO_W = flash_pin_pkg::BYTE_W,
  parameter int FIFO_D = flash_pin_pkg::FIFO_DEPTH
) (
  input  wire logic                                clock,
  input  wire logic                                rst,
  input  wire logic                                cs_n,
  input  wire logic                                sck,
  input  wire logic                                si,
  output var  logic                                so_o,
  output var  logic                                so_oe,
  input  wire logic                                wp_n,
  input  wire logic                                page_512,
  input  wire logic                                sw_prot_en,
  input  wire logic                                prot_wr,
  input  wire logic [flash_pin_pkg::SECTORS-1:0]   prot_wdata,
  output var  logic [flash_pin_pkg::SECTORS-1:0]   prot_map,
  output var  logic                                hdr_valid,
  output var  logic [flash_pin_pkg::OPC_BITS-1:0]  hdr_opcode,
  output var  logic [flash_pin_pkg::ADDR_BITS-1:0] hdr_addr,
  output var  logic [flash_pin_pkg::PAGE_BITS-1:0] hdr_page,
  input  wire logic                                hdr_is_read,
  input  wire logic                                hdr_is_modify,
  input  wire logic                                hdr_is_prot_cmd,
  output var  logic                                cmd_blocked,
  output var  logic [FIFO_W-1:0]                   wr_data,
  output var  logic                                wr_valid,
  input  wire logic                                wr_ready,
  output var  logic                                wr_overrun,
  output var  logic [flash_pin_pkg::CNT_W-1:0]     wr_count,
  input  wire logic [flash_pin_pkg::BYTE_W-1:0]    rd_data,
  input  wire logic                                rd_valid,
  output var  logic                                rd_ready,
  output var  logic                                start_op,
  input  wire logic                                array_busy,
  output var  logic                                standby
);

  import flash_pin_pkg::*;

  typedef struct packed {
    state_t               st;
    logic                 sck_p;
    logic                 cs_p;
    logic [BYTE_W-1:0]    sh;
    logic [BITC_W-1:0]    bitc;
    logic [OPC_BITS-1:0]  opc;
    logic [ADDR_BITS-1:0] addr;
    logic [CNT_W-1:0]     nbytes;
    logic [BYTE_W-1:0]    tx;
    logic                 so;
    logic                 oe;
    logic                 hdr_valid;
    logic                 start_op;
    logic                 modify;
    logic                 blocked;
    logic                 overrun;
    logic                 standby;
    logic [SECTORS-1:0]   prot;
  } regs_t;

  regs_t             q;
  regs_t             d;
  logic [3:0]        pins_s;
  logic              cs_s;
  logic              sck_s;
  logic              si_s;
  logic              wp_s;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic [BYTE_W-1:0] sh_next;
  logic [CNT_W-1:0]  page_limit;
  logic [SEC_BITS-1:0] sector;
  logic              sec_blocked;
  logic              push;
  logic              push_ready;
  logic              take_rd;

  // Slow pins are resampled on the system clock; sck is just another input
  // Select and protect enter inverted so a cleared synchroniser reads idle
  pin_sync #(
    .W (4)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     ({~cs_n, sck, si, ~wp_n}),
    .q     (pins_s)
  );

  assign cs_s  = ~pins_s[3];
  assign sck_s = pins_s[2];
  assign si_s  = pins_s[1];
  assign wp_s  = ~pins_s[0];

  // Rising-edge capture serves both mode 0 and mode 3 idle levels
  assign sck_rise = sck_s & ~q.sck_p;
  assign sck_fall = ~sck_s & q.sck_p;
  assign cs_fall  = ~cs_s & q.cs_p;
  assign cs_rise  = cs_s & ~q.cs_p;
  assign sh_next  = {q.sh[BYTE_W-2:0], si_s};

  // 528 unless the binary page size is chosen
  assign page_limit = page_512 ? PAGE_SHORT : PAGE_LONG;
  assign hdr_page   = page_512 ? q.addr[PAGE_LSB_SHORT +: PAGE_BITS]
                               : q.addr[PAGE_LSB_LONG +: PAGE_BITS];
  assign sector     = hdr_page[SEC_LSB +: SEC_BITS];

  // Pin protection alone suffices; software enable is an independent path
  assign sec_blocked = hdr_is_modify & ~hdr_is_prot_cmd & q.prot[sector]
                       & (~wp_s | sw_prot_en);

  // Blocked frames neither count nor push, so no overrun either
  assign push     = (q.st == ST_DATA) & ~cs_s & sck_rise & (q.bitc == BYTE_LAST)
                    & q.modify & (q.nbytes < page_limit)
                    & ~q.blocked;
  assign take_rd  = ((q.st == ST_DECIDE) & hdr_is_read & ~sec_blocked)
                    | ((q.st == ST_READ) & ~cs_s & sck_fall & (q.bitc == BYTE_LAST));
  assign rd_ready = take_rd;

  always_comb begin
    d           = q;
    d.sck_p     = sck_s;
    d.cs_p      = cs_s;
    d.hdr_valid = 1'b0;
    d.start_op  = 1'b0;
    // Map changes refused while write protect is held low
    if (prot_wr & wp_s) begin
      d.prot = prot_wdata;
    end
    if (cs_s) begin
      // Deselected: input ignored, frame closed
      // Only a frame that reached its data phase starts a timed cycle
      if (cs_rise & q.modify & ~q.blocked & (q.st == ST_DATA)) begin
        d.start_op = 1'b1;
      end
      d.st     = ST_IDLE;
      d.bitc   = '0;
      d.modify = 1'b0;
      // No stale bits shown at the start of the next read
      d.so     = 1'b0;
      d.tx     = '0;
    end else begin
      case (q.st)
        ST_IDLE: begin
          // A select already low at reset release opens a frame once it passes the synchroniser
          if (cs_fall) begin
            d.st      = ST_OPC;
            d.bitc    = '0;
            d.nbytes  = '0;
            d.overrun = 1'b0;
            d.blocked = 1'b0;
          end
        end
        ST_OPC: begin
          // A mode 3 idle fall before the first bit is simply ignored
          if (sck_rise) begin
            d.sh   = sh_next;
            d.bitc = q.bitc + 1'b1;
            if (q.bitc == OPC_LAST) begin
              d.opc  = sh_next;
              d.st   = ST_ADDR;
              d.bitc = '0;
            end
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            d.addr = {q.addr[ADDR_BITS-2:0], si_s};
            d.bitc = q.bitc + 1'b1;
            if (q.bitc == ADDR_LAST) begin
              d.st        = ST_DECIDE;
              d.hdr_valid = 1'b1;
              d.bitc      = '0;
            end
          end
        end
        ST_DECIDE: begin
          // One system clock for the opcode decode; sck is far slower
          d.modify  = hdr_is_modify;
          d.blocked = sec_blocked;
          if (sec_blocked) begin
            d.st = ST_DATA;
          end else if (hdr_is_read) begin
            d.tx = rd_valid ? rd_data : '0;
            d.st = ST_READ;
          end else begin
            d.st = ST_DATA;
          end
        end
        ST_DATA: begin
          if (sck_rise) begin
            d.sh   = sh_next;
            d.bitc = (q.bitc == BYTE_LAST) ? '0 : q.bitc + 1'b1;
            // Bytes past the page end are dropped, never wrapped
            if (push) begin
              d.nbytes = q.nbytes + 1'b1;
              if (~push_ready) begin
                d.overrun = 1'b1;
              end
            end
          end
        end
        ST_READ: begin
          if (sck_fall) begin
            d.so   = q.tx[BYTE_W-1];
            d.tx   = {q.tx[BYTE_W-2:0], 1'b0};
            d.bitc = (q.bitc == BYTE_LAST) ? '0 : q.bitc + 1'b1;
            // Next byte fetched on the eighth fall; an empty source sends zeros
            if (q.bitc == BYTE_LAST) begin
              d.tx = rd_valid ? rd_data : '0;
            end
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
    end
    // Standby only once no timed cycle is in flight
    d.standby = cs_s & ~array_busy & ~d.start_op & ~q.start_op;

    // Enable registered so the pin never sees a decode glitch
    d.oe      = ~cs_s & (d.st == ST_READ);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q      <= '0;
      q.st   <= ST_IDLE;
      // Select history starts deselected to avoid a false edge
      q.cs_p <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Blocked commands still run the frame but write nothing
  byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push & ~q.blocked),
    .in_ready  (push_ready),
    .in_data   (FIFO_W'(sh_next)),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  assign so_o        = q.so;
  assign so_oe       = q.oe;
  assign prot_map    = q.prot;
  assign hdr_valid   = q.hdr_valid;
  assign hdr_opcode  = q.opc;
  assign hdr_addr    = q.addr;
  assign cmd_blocked = q.blocked;
  assign wr_overrun  = q.overrun;
  assign wr_count    = q.nbytes;
  assign start_op    = q.start_op;
  assign standby     = q.standby;

  // Sizing of the array and one-time area is fixed by the package
  localparam int TOTAL_PAGES = PAGES;
  localparam int BUF_COUNT   = BUFFERS;
  localparam int OTP_USER    = OTP_BYTES - OTP_FACTORY;

endmodule : serial_flash_pin_interface

`default_nettype wire

// File: serial_flash_pin_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_pin_checker (
  input wire logic                              clock,
  input wire logic                              rst,
  input wire logic                              cs_n,
  input wire logic                              sck,
  input wire logic                              so_o,
  input wire logic                              so_oe,
  input wire logic                              wp_n,
  input wire logic                              page_512,
  input wire logic                              prot_wr,
  input wire logic [flash_pin_pkg::SECTORS-1:0] prot_wdata,
  input wire logic [flash_pin_pkg::SECTORS-1:0] prot_map,
  input wire logic                              hdr_valid,
  input wire logic                              cmd_blocked,
  input wire logic [flash_pin_pkg::CNT_W-1:0]   wr_count,
  input wire logic                              start_op,
  input wire logic                              array_busy,
  input wire logic                              standby
);
  import flash_pin_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Six cycles cover the select synchroniser and the output register
  chk_oe_idle: assert property (cs_n [*6] |-> !so_oe)
    else $error("serial output driven while deselected");
  chk_so_edge: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !$past(sck, 2))
    else $error("serial output changed outside a low clock phase");
  chk_hdr_sel: assert property (hdr_valid |-> !$past(cs_n, 4))
    else $error("header completed without select");
  chk_start_ok: assert property (start_op |-> cs_n && !cmd_blocked)
    else $error("start pulse for a blocked or open command");
  chk_busy_hold: assert property ($past(array_busy) |-> !standby)
    else $error("standby while timed cycle runs");
  chk_sel_awake: assert property (!cs_n [*6] |-> !standby)
    else $error("standby while selected");
  chk_sby_entry: assert property ($fell(array_busy) && cs_n |-> ##[1:4] standby)
    else $error("standby not entered after timed cycle");
  chk_map_lock: assert property (!wp_n [*4] |=> $stable(prot_map))
    else $error("protection map changed under write protect");
  chk_map_load: assert property (wp_n [*4] ##0 prot_wr |=> prot_map == $past(prot_wdata))
    else $error("protection map not loaded");
  chk_cnt_page: assert property (wr_count <= (page_512 ? PAGE_SHORT : PAGE_LONG))
    else $error("byte count beyond page size");
  cov_header: cover property (hdr_valid);
  cov_start: cover property (start_op);
  cov_block: cover property ($rose(cmd_blocked));
endmodule : serial_flash_pin_checker
bind serial_flash_pin_interface serial_flash_pin_checker u_chk (
  .clock, .rst, .cs_n, .sck, .so_o, .so_oe, .wp_n, .page_512, .prot_wr, .prot_wdata,
  .prot_map, .hdr_valid, .cmd_blocked, .wr_count, .start_op, .array_busy, .standby);
`default_nettype wire

// File: spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic clock,
  input  wire logic so_o,
  input  wire logic so_oe,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  logic mode3    = 1'b0;
  logic last_bit = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic half();
    repeat (8) @(posedge clock);
  endtask : half
  // Clock parks at the mode level between frames
  task automatic sel(input logic m3);
    mode3 = m3;
    @(posedge clock) sck <= m3;
    half();
    cs_n <= 1'b0;
    half();
  endtask : sel
  // Launch on the fall, device takes it on the rise, MSB first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= tx[i];
      half();
      rx[i]    = so_oe ? so_o : ~last_bit;
      last_bit = rx[i];
      sck <= 1'b1;
      half();
    end
  endtask : xfer
  task automatic desel();
    sck <= mode3;
    half();
    cs_n <= 1'b1;
    si   <= ~si;
    half();
  endtask : desel
endmodule : spi_host_model
`default_nettype wire

// File: serial_flash_pin_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module serial_flash_pin_interface_tb_top;
  import flash_pin_pkg::*;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 cs_n, sck, si, so_o, so_oe, hdr_valid, cmd_blocked;
  logic                 wr_valid, wr_overrun, rd_ready, start_op, standby;
  logic [SECTORS-1:0]   prot_map;
  logic [OPC_BITS-1:0]  hdr_opcode;
  logic [ADDR_BITS-1:0] hdr_addr;
  logic [PAGE_BITS-1:0] hdr_page;
  logic [BYTE_W-1:0]    wr_data;
  logic [CNT_W-1:0]     wr_count;
  logic                 wp_n = 1'b1, page_512 = 1'b0, sw_prot_en = 1'b0, prot_wr = 1'b0;
  logic                 hdr_is_read = 1'b0, hdr_is_modify = 1'b0, hdr_is_prot_cmd = 1'b0;
  logic                 wr_ready = 1'b0, rd_valid = 1'b0, array_busy = 1'b0;
  logic [SECTORS-1:0]   prot_wdata = '0;
  logic [BYTE_W-1:0]    rd_data = '0;
  logic [7:0]           got[$];
  int                   n_hdr = 0, n_start = 0, miscompares = 0, samples_checked = 0;
  int                   n_rd = 0;

  serial_flash_pin_interface DUT (.clock, .rst, .cs_n, .sck, .si, .so_o, .so_oe, .wp_n,
    .page_512, .sw_prot_en, .prot_wr, .prot_wdata, .prot_map, .hdr_valid, .hdr_opcode,
    .hdr_addr, .hdr_page, .hdr_is_read, .hdr_is_modify, .hdr_is_prot_cmd, .cmd_blocked,
    .wr_data, .wr_valid, .wr_ready, .wr_overrun, .wr_count, .rd_data, .rd_valid, .rd_ready,
    .start_op, .array_busy, .standby);
  spi_host_model host (.clock, .so_o, .so_oe, .cs_n, .sck, .si);

  initial begin
    forever #5 clock = ~clock;
  end
  // Array side: a started cycle reports busy until a test ends it
  always @(posedge clock) begin
    if (hdr_valid === 1'b1) n_hdr++;
    if (start_op === 1'b1) n_start++;
    if (rd_ready === 1'b1) n_rd++;
    if (start_op === 1'b1) array_busy <= 1'b1;
    if (wr_valid === 1'b1 && wr_ready) got.push_back(wr_data);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic frame(input logic m3, input logic [7:0] opc, input logic [23:0] adr,
                       input int nb, output logic [7:0] rx);
    host.sel(m3);
    host.xfer(opc, rx);
    for (int i = 2; i >= 0; i--) host.xfer(adr[8*i +: 8], rx);
    for (int i = 0; i < nb; i++) host.xfer(8'h10 + i[7:0], rx);
    host.desel();
  endtask : frame
  task automatic pwrite(input logic [15:0] v);
    prot_wdata <= v;
    prot_wr    <= 1'b1;
    @(posedge clock);
    prot_wr <= 1'b0;
    tick(2);
  endtask : pwrite

  // 32 clock rises while deselected must not build a header
  task automatic t_noise();
    logic [7:0] rx;
    int         h;
    h = n_hdr;
    @(posedge clock);
    for (int i = 0; i < 4; i++) host.xfer(8'ha5, rx);
    tick(8);
    check(n_hdr, h);
    check(so_oe, 1'b0);
  endtask : t_noise

  // Five bytes into a stalled four-deep buffer, then drain
  task automatic t_write();
    logic [7:0] rx;
    int         s;
    int         h;
    s = n_start;
    h = n_hdr;
    got.delete();
    hdr_is_modify <= 1'b1;
    frame(1'b0, 8'h82, 24'h0c0000, 5, rx);
    check(hdr_opcode, 8'h82);
    check(hdr_addr, 24'h0c0000);
    check(hdr_page, 12'h300);
    check(wr_overrun, 1'b1);
    check(wr_count, 10'h005);
    check(n_hdr, h + 1);
    check(n_start, s + 1);
    tick(30);
    check(standby, 1'b0);
    array_busy <= 1'b0;
    tick(6);
    check(standby, 1'b1);
    wr_ready <= 1'b1;
    tick(10);
    check(got.size(), 4);
    for (int i = 0; i < 4; i++) check(got[i], 8'h10 + i[7:0]);
    page_512 <= 1'b1;
    tick(2);
    check(hdr_page, 12'h600);
    page_512      <= 1'b0;
    hdr_is_modify <= 1'b0;
  endtask : t_write

  task automatic t_prot();
    logic [7:0] rx;
    int         s;
    s = n_start;
    pwrite(16'h0008);
    check(prot_map, 16'h0008);
    wp_n <= 1'b0;
    tick(4);
    pwrite(16'hffff);
    check(prot_map, 16'h0008);
    hdr_is_modify <= 1'b1;
    frame(1'b0, 8'h83, 24'h0c0000, 1, rx);
    check(cmd_blocked, 1'b1);
    check(wr_count, 10'h000);
    hdr_is_prot_cmd <= 1'b1;
    frame(1'b0, 8'h3d, 24'h0c0000, 1, rx);
    check(cmd_blocked, 1'b0);
    check(wr_count, 10'h001);
    check(n_start, s + 1);
    array_busy      <= 1'b0;
    hdr_is_prot_cmd <= 1'b0;
    wp_n            <= 1'b1;
    sw_prot_en      <= 1'b1;
    frame(1'b0, 8'h83, 24'h0c0000, 1, rx);
    check(cmd_blocked, 1'b1);
    check(wr_count, 10'h000);
    check(n_start, s + 1);
    sw_prot_en    <= 1'b0;
    hdr_is_modify <= 1'b0;
  endtask : t_prot

  // One read in each clock mode
  task automatic t_read();
    logic [7:0] rx;
    int         r;
    hdr_is_read <= 1'b1;
    rd_data     <= 8'hc6;
    rd_valid    <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      r = n_rd;
      frame(m[0], 8'h0b, 24'h000100, 1, rx);
      check(rx, 8'hc6);
      check(n_rd - r, 2);
      check(so_oe, 1'b0);
    end
    hdr_is_read <= 1'b0;
    rd_valid    <= 1'b0;
  endtask : t_read

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    tick(5);
    t_noise();
    t_write();
    t_prot();
    t_read();
    finish_test();
  end
  // Tests need well under 100 us
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
endmodule : serial_flash_pin_interface_tb_top
`default_nettype wire
